//--- core/lane_rx_ordered_set_flags.sv
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "lane_rx_os_regs.svh"

// Summary of operation
// - FTS ordered set on lane i sets fast-training flag i.
// - SKP ordered set on lane i sets skip flag i.
// - Idle-exit ordered set on lane i sets idle-exit flag i.
// - Idle ordered set on lane i sets idle-set flag i.
// - A set flag stays 1 until software writes 1 there.
// - Reg 0xb4: idle-exit flags in 31:16, idle-set in 15:0, reset 0.
// - Reg 0xb0: fast-training flags in 31:16, skip in 15:0, reset 0.
module lane_rx_ordered_set_flags (
  input wire logic CLK_IN, // 20 MHz management clock
  input wire logic RST_IN, // Async reset, active high
  input wire lane_rx_os_pkg::apb_req_t APB_IN, // APB request
  input wire lane_rx_os_pkg::lane_det_t DET_IN, // Detection pulses
  output logic PREADY_OUT, // APB ready
  output logic [31:0] PRDATA_OUT, // APB read data
  output logic PSLVERR_OUT, // APB error, unmapped address
  output logic IRQ_OUT // Level interrupt
);
  import lane_rx_os_pkg::*;

  // ========================================================
  // APB decode
  logic setup_c;
  logic access_c;
  logic wr_acc_c;
  logic hit_ts_c;
  logic hit_idle_c;
  logic hit_mts_c;
  logic hit_midle_c;
  logic mapped_c;
  logic [31:0] clr_ts_c;
  logic [31:0] clr_idle_c;

  always_comb begin
    setup_c = APB_IN.psel & ~APB_IN.penable;
    access_c = APB_IN.psel & APB_IN.penable & PREADY_OUT;
    wr_acc_c = access_c & APB_IN.pwrite;
    hit_ts_c = (APB_IN.paddr == `LRX_OFS_TRAIN_SKP);
    hit_idle_c = (APB_IN.paddr == `LRX_OFS_IDLE);
    hit_mts_c = (APB_IN.paddr == `LRX_OFS_MASK_TRAIN_SKP);
    hit_midle_c = (APB_IN.paddr == `LRX_OFS_MASK_IDLE);
    mapped_c = hit_ts_c | hit_idle_c | hit_mts_c | hit_midle_c;
    // Only ones in the write data clear; zeros leave flags alone
    clr_ts_c = (wr_acc_c & hit_ts_c) ? APB_IN.pwdata : 32'h0;
    clr_idle_c = (wr_acc_c & hit_idle_c) ? APB_IN.pwdata : 32'h0;
  end

  // ========================================================
  // Sticky flags, one slice per lane
  logic [15:0] fts_q;
  logic [15:0] skp_q;
  logic [15:0] eie_q;
  logic [15:0] eios_q;
  logic [15:0] fts_d;
  logic [15:0] skp_d;
  logic [15:0] eie_d;
  logic [15:0] eios_d;

  genvar g;
  generate
    for (g = 0; g < `LRX_LANES; g++) begin : g_lane
      always_comb begin
        // Set has priority so an event during a clear is kept
        fts_d[g] = DET_IN.fts[g] |
                   (fts_q[g] & ~clr_ts_c[`LRX_FTS_LSB + g]);
        skp_d[g] = DET_IN.skp[g] |
                   (skp_q[g] & ~clr_ts_c[`LRX_SKP_LSB + g]);
        eie_d[g] = DET_IN.eie[g] |
                   (eie_q[g] & ~clr_idle_c[`LRX_EIE_LSB + g]);
        eios_d[g] = DET_IN.eios[g] |
                    (eios_q[g] & ~clr_idle_c[`LRX_EIOS_LSB + g]);
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fts_q <= `LRX_LANE_RST;
      skp_q <= `LRX_LANE_RST;
      eie_q <= `LRX_LANE_RST;
      eios_q <= `LRX_LANE_RST;
    end else begin
      fts_q <= fts_d;
      skp_q <= skp_d;
      eie_q <= eie_d;
      eios_q <= eios_d;
    end
  end

  // ========================================================
  // Status words as software sees them
  logic [31:0] stat_ts_c;
  logic [31:0] stat_idle_c;

  always_comb begin
    stat_ts_c = {fts_q, skp_q};
    stat_idle_c = {eie_q, eios_q};
  end

  // ========================================================
  // Interrupt masks, same layout as the status words
  logic [31:0] mask_ts_q;
  logic [31:0] mask_idle_q;
  logic [31:0] mask_ts_d;
  logic [31:0] mask_idle_d;
  logic irq_d;

  always_comb begin
    mask_ts_d = mask_ts_q;
    mask_idle_d = mask_idle_q;
    if (wr_acc_c & hit_mts_c) begin
      mask_ts_d = APB_IN.pwdata;
    end
    if (wr_acc_c & hit_midle_c) begin
      mask_idle_d = APB_IN.pwdata;
    end
    // Registered, so it lags the flag by one cycle
    irq_d = |((stat_ts_c & mask_ts_q) | (stat_idle_c & mask_idle_q));
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_ts_q <= `LRX_MASK_RST;
      mask_idle_q <= `LRX_MASK_RST;
      IRQ_OUT <= 1'b0;
    end else begin
      mask_ts_q <= mask_ts_d;
      mask_idle_q <= mask_idle_d;
      IRQ_OUT <= irq_d;
    end
  end

  // ========================================================
  // APB answer: no wait state, data captured in setup
  logic pready_d;
  logic [31:0] prdata_d;
  logic pslverr_d;

  always_comb begin
    pready_d = setup_c;
    prdata_d = PRDATA_OUT;
    pslverr_d = 1'b0;
    if (setup_c) begin
      pslverr_d = ~mapped_c;
      prdata_d = 32'h0;
      if (~APB_IN.pwrite) begin
        unique case (1'b1)
          hit_ts_c: prdata_d = stat_ts_c;
          hit_idle_c: prdata_d = stat_idle_c;
          hit_mts_c: prdata_d = mask_ts_q;
          hit_midle_c: prdata_d = mask_idle_q;
          default: prdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= pready_d;
      PRDATA_OUT <= prdata_d;
      PSLVERR_OUT <= pslverr_d;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  fts_set_a: assert property (
    (|DET_IN.fts) |=> ((fts_q & $past(DET_IN.fts)) == $past(DET_IN.fts)))
    else $error("fast-training flag not set by detection");

  skp_set_a: assert property (
    (|DET_IN.skp) |=> ((skp_q & $past(DET_IN.skp)) == $past(DET_IN.skp)))
    else $error("skip flag not set by detection");

  eie_set_a: assert property (
    (|DET_IN.eie) |=> ((eie_q & $past(DET_IN.eie)) == $past(DET_IN.eie)))
    else $error("idle-exit flag not set by detection");

  eios_set_a: assert property (
    (|DET_IN.eios) |=>
      ((eios_q & $past(DET_IN.eios)) == $past(DET_IN.eios)))
    else $error("idle-set flag not set by detection");

  flag_hold_a: assert property (
    1 |=> (($past(stat_ts_c) & ~$past(clr_ts_c) & ~stat_ts_c) == 32'h0) &&
          (($past(stat_idle_c) & ~$past(clr_idle_c) & ~stat_idle_c)
           == 32'h0))
    else $error("flag dropped without a write of one");

  flag_clear_a: assert property (
    (|clr_idle_c) |=>
      ((stat_idle_c & $past(clr_idle_c) &
        ~$past({DET_IN.eie, DET_IN.eios})) == 32'h0))
    else $error("write of one did not clear idle flag");

  idle_layout_a: assert property (
    (setup_c && !APB_IN.pwrite && hit_idle_c) |=>
      (PRDATA_OUT == {$past(eie_q), $past(eios_q)}) && PREADY_OUT)
    else $error("idle status read returned wrong word");

  ts_layout_a: assert property (
    (setup_c && !APB_IN.pwrite && hit_ts_c) |=>
      (PRDATA_OUT[31:16] == $past(fts_q)) &&
      (PRDATA_OUT[15:0] == $past(skp_q)))
    else $error("training/skip read returned wrong word");

  set_wins_a: assert property (
    (|(clr_ts_c[31:16] & DET_IN.fts)) |=>
      ((fts_q & $past(clr_ts_c[31:16] & DET_IN.fts)) ==
       $past(clr_ts_c[31:16] & DET_IN.fts)))
    else $error("clear beat a same-cycle detection");

  // Race cases per field, so a swapped clear slice shows up
  skp_wins_a: assert property (
    (|(clr_ts_c[15:0] & DET_IN.skp)) |=>
      ((skp_q & $past(clr_ts_c[15:0] & DET_IN.skp)) ==
       $past(clr_ts_c[15:0] & DET_IN.skp)))
    else $error("clear beat a same-cycle skip detection");

  eie_wins_a: assert property (
    (|(clr_idle_c[31:16] & DET_IN.eie)) |=>
      ((eie_q & $past(clr_idle_c[31:16] & DET_IN.eie)) ==
       $past(clr_idle_c[31:16] & DET_IN.eie)))
    else $error("clear beat a same-cycle idle-exit detection");

  eios_wins_a: assert property (
    (|(clr_idle_c[15:0] & DET_IN.eios)) |=>
      ((eios_q & $past(clr_idle_c[15:0] & DET_IN.eios)) ==
       $past(clr_idle_c[15:0] & DET_IN.eios)))
    else $error("clear beat a same-cycle idle-set detection");

  ts_clear_a: assert property (
    (|clr_ts_c) |=>
      ((stat_ts_c & $past(clr_ts_c) &
        ~$past({DET_IN.fts, DET_IN.skp})) == 32'h0))
    else $error("write of one did not clear training/skip flag");

  // Only a detection may raise a flag, never a bus access
  flag_rise_a: assert property (
    1 |=> ((stat_ts_c & ~$past(stat_ts_c) &
            ~$past({DET_IN.fts, DET_IN.skp})) == 32'h0) &&
          ((stat_idle_c & ~$past(stat_idle_c) &
            ~$past({DET_IN.eie, DET_IN.eios})) == 32'h0))
    else $error("flag rose without a detection");

  ready_after_a: assert property (
    setup_c |=> PREADY_OUT)
    else $error("no ready in the cycle after setup");

  ready_pulse_a: assert property (
    PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");

  err_unmapped_a: assert property (
    (setup_c && !mapped_c) |=> (PSLVERR_OUT && (PRDATA_OUT == 32'h0)))
    else $error("unmapped access not refused");

  err_mapped_a: assert property (
    (setup_c && mapped_c) |=> !PSLVERR_OUT)
    else $error("mapped access flagged as error");

  wr_data_zero_a: assert property (
    (setup_c && APB_IN.pwrite) |=> (PRDATA_OUT == 32'h0))
    else $error("read data not zero on a write");

  prdata_hold_a: assert property (
    !setup_c |=> $stable(PRDATA_OUT))
    else $error("read data moved outside a setup cycle");

  mask_ts_wr_a: assert property (
    (wr_acc_c && hit_mts_c) |=> (mask_ts_q == $past(APB_IN.pwdata)))
    else $error("training/skip mask write lost");

  mask_idle_wr_a: assert property (
    (wr_acc_c && hit_midle_c) |=> (mask_idle_q == $past(APB_IN.pwdata)))
    else $error("idle mask write lost");

  // Interrupt judged from flags and masks, not from the next-state term
  irq_level_a: assert property (
    (|(stat_ts_c & mask_ts_q) || |(stat_idle_c & mask_idle_q)) |=> IRQ_OUT)
    else $error("interrupt missing for a masked-in flag");

  irq_quiet_a: assert property (
    !(|(stat_ts_c & mask_ts_q) || |(stat_idle_c & mask_idle_q)) |=>
      !IRQ_OUT)
    else $error("interrupt raised with no masked-in flag");

  cov_clear_c: cover property (wr_acc_c && hit_idle_c ##1 eios_q == 16'h0);
  cov_race_c: cover property (|(clr_ts_c & {DET_IN.fts, DET_IN.skp}));
  cov_irq_c: cover property (!IRQ_OUT ##1 IRQ_OUT);
  cov_err_c: cover property (PSLVERR_OUT && PREADY_OUT);
  cov_race_idle_c: cover property (|(clr_idle_c & {DET_IN.eie, DET_IN.eios}));

endmodule

//--- pkg/lane_rx_os_pkg.sv
package lane_rx_os_pkg;

  // ========================================================
  // Per-lane detection pulses from the receive path
  typedef struct packed {
    logic [15:0] fts;
    logic [15:0] skp;
    logic [15:0] eie;
    logic [15:0] eios;
  } lane_det_t;

  // ========================================================
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

//--- pkg/lane_rx_os_regs.svh
`ifndef LANE_RX_OS_REGS_SVH
`define LANE_RX_OS_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LRX_ADDR_W 12
`define LRX_OFS_TRAIN_SKP 12'h0b0
`define LRX_OFS_IDLE 12'h0b4
`define LRX_OFS_MASK_TRAIN_SKP 12'h0b8
`define LRX_OFS_MASK_IDLE 12'h0bc

// ==========================================================
// Field positions
`define LRX_FTS_LSB 16
`define LRX_SKP_LSB 0
`define LRX_EIE_LSB 16
`define LRX_EIOS_LSB 0
`define LRX_LANES 16

// ==========================================================
// Reset values
`define LRX_STATUS_RST 32'h0000_0000
`define LRX_MASK_RST 32'h0000_0000
`define LRX_LANE_RST 16'h0000

`endif

//--- test/lane_rx_ordered_set_flags_tb.sv
`timescale 1ns/1ns
module lane_rx_ordered_set_flags_tb;
  import lane_rx_os_pkg::*;
  typedef struct {
    logic [1:0] k;
    logic [15:0] l;
    logic [11:0] a;
    logic [31:0] e;
  } row_t;
  logic clk, rst, go, pready, pslverr, irq, err;
  logic [1:0] kind;
  logic [15:0] lanes;
  logic [31:0] prdata, rd;
  apb_req_t apb;
  lane_det_t det;
  int n_errors = 0;
  int checked = 0;
  // Edge lanes 0 and 15 (1 and 14 for idle-exit) catch a reversed or shifted field
  row_t rows [4] = '{'{2'd0, 16'h8001, 12'h0b0, 32'h8001_0000},
    '{2'd1, 16'h8001, 12'h0b0, 32'h0000_8001},
    '{2'd2, 16'h4002, 12'h0b4, 32'h4002_0000},
    '{2'd3, 16'h8001, 12'h0b4, 32'h0000_8001}};
  lane_rx_ordered_set_flags dut (.CLK_IN(clk), .RST_IN(rst),
    .APB_IN(apb), .DET_IN(det), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
  os_source far (.clk_in(clk), .go_in(go), .kind_in(kind),
    .lanes_in(lanes), .det_out(det));
  // ==========================================================
  // Helpers
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    // Look between edges; only the watchdog ends a wait
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [1:0] k, input logic [15:0] l);
    @(posedge clk);
    kind <= k;
    lanes <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 3000);
    n_errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    go = 1'b0;
    kind = '0;
    lanes = '0;
    apb = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 12'h0b0, 0);
    chk(rd, 32'h0);
    bus(0, 12'h0b4, 0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      send(rows[i].k, rows[i].l);
      bus(0, rows[i].a, 0);
      chk(rd, rows[i].e);
      bus(1, rows[i].a, 32'h0);
      bus(0, rows[i].a, 0);
      chk(rd, rows[i].e);
      bus(1, rows[i].a, rows[i].e);
      bus(0, rows[i].a, 0);
      chk(rd, 32'h0);
    end
    // Masked lane raises the line, an unmasked one must not
    bus(1, 12'h0b8, 32'h0000_0008);
    send(1, 16'h0008);
    repeat (3) @(posedge clk);
    chk({31'b0, irq}, 32'h1);
    bus(1, 12'h0b0, 32'h0000_0008);
    send(1, 16'h0010);
    repeat (3) @(posedge clk);
    chk({31'b0, irq}, 32'h0);
    // Detection coinciding with a clearing write must survive it
    // One pulse, landing on the very edge that applies the write
    @(posedge clk);
    kind <= 2'd3;
    lanes <= 16'h0001;
    fork
      bus(1, 12'h0b4, 32'h0000_0001);
      begin
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
      end
    join
    bus(0, 12'h0b4, 0);
    chk(rd, 32'h0000_0001);
    chk({31'b0, err}, 32'h0);
    bus(0, 12'h0c0, 0);
    chk({31'b0, err}, 32'h1);
    chk(rd, 32'h0);
    send(0, 16'h8000);
    bus(0, 12'h0b0, 0);
    chk(rd, 32'h8000_0010);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    bus(0, 12'h0b0, 0);
    chk(rd, 32'h0);
    chk({31'b0, irq}, 32'h0);
    stop_test();
  end
endmodule

//--- test/os_source.sv
`timescale 1ns/1ns
// ==========================================================
// Far-end stand-in: emits one ordered set per cycle of go_in
module os_source (
  input wire logic clk_in, // Clock
  input wire logic go_in, // Send while high
  input wire logic [1:0] kind_in, // 0 fts 1 skp 2 eie 3 eios
  input wire logic [15:0] lanes_in, // Lanes that see it
  output lane_rx_os_pkg::lane_det_t det_out // Detection pulses
);
  import lane_rx_os_pkg::*;
  lane_det_t det_d;
  always_comb begin
    det_d = '0;
    if (go_in) begin
      case (kind_in)
        2'd0: det_d.fts = lanes_in;
        2'd1: det_d.skp = lanes_in;
        2'd2: det_d.eie = lanes_in;
        default: det_d.eios = lanes_in;
      endcase
    end
  end
  // Quiet until asked, so no stray detections after reset
  initial det_out = '0;
  always @(posedge clk_in) begin
    det_out <= det_d;
  end
endmodule
